//--- hdl/agclk_pkg.sv
// Constants for the gain-control thresholds and lock detector block
// Summary of operation
// R01: Strength level is averaged magnitude quantised to 1.5 dB steps, used everywhere.
// R02: Lower gain when level exceeds sense + 8 + raise margin + 3 + drop margin.
// R03: Raise gain when level is below sense + 8 + raise margin, unless at maximum.
// R04: Start gain, reset 24, is loaded whenever the receive chain turns on.
// R05: The gain loop never steps gain above start gain.
// R06: Sense threshold, reset 24, is the reference for carrier sense and gain control.
// R07: Source code 4 drives pin low while strength is above carrier-sense threshold.
// R08: Source 0 forces low, 1 forces high, 7 to 15 route clock and comparator taps.
// R09: Codes 2, 3, 5, 6 drive active-low steady, instant, calibration, fault flags.
// R10: Phase comparison is in window below 2 prescaler cycles, or 4 when span set.
// R11: Detector counter style is restart when style bit is 0, up/down when 1.
// R12: Lock at 127/255/511/1023, lost at 111/239/495/1007, chosen by threshold select.
// R13: Host picks source 2 to use the pin as a continuous lock indicator.
// R14: With auto gain off, gain is held at start gain.
// R15: Magnitude is averaged over 2, 4, 8 or 16 samples before comparisons.
// R16: Restart style clears on a miss; up/down style decrements on a miss.
package agclk_pkg;
   localparam logic [6:0] ADDR_GAIN_START  = 7'h13;
   localparam logic [6:0] ADDR_GAIN_RAISE  = 7'h14;
   localparam logic [6:0] ADDR_LOCK_CFG    = 7'h15;
   localparam logic [7:0] RST_GAIN_START   = 8'h38;
   localparam logic [7:0] RST_GAIN_RAISE   = 8'h38;
   localparam logic [7:0] RST_LOCK_CFG     = 8'h00;
   // Field positions inside the configuration bytes
   localparam int         F_MARGIN_LSB     = 5;
   localparam int         F_LEVEL_MSB      = 4;
   localparam int         F_SRC_LSB        = 4;
   localparam int         F_SPAN_BIT       = 3;
   localparam int         F_STYLE_BIT      = 2;
   localparam int         F_AUTO_OFF_BIT   = 0;
   localparam int         F_AVG_LSB        = 1;
   // Threshold offsets, in 1.5 dB steps
   localparam logic [7:0] SENSE_OFFSET     = 8'h08;
   localparam logic [7:0] DROP_BASE        = 8'h03;
   localparam logic [7:0] LEVEL_DIVISOR    = 8'h03;
   localparam logic [3:0] WINDOW_NARROW    = 4'h2;
   localparam logic [3:0] WINDOW_WIDE      = 4'h4;
   localparam logic [9:0] LOCK_THR_0       = 10'h07F;
   localparam logic [9:0] LOCK_THR_1       = 10'h0FF;
   localparam logic [9:0] LOCK_THR_2       = 10'h1FF;
   localparam logic [9:0] LOCK_THR_3       = 10'h3FF;
   localparam logic [9:0] LOSS_THR_0       = 10'h06F;
   localparam logic [9:0] LOSS_THR_1       = 10'h0EF;
   localparam logic [9:0] LOSS_THR_2       = 10'h1EF;
   localparam logic [9:0] LOSS_THR_3       = 10'h3EF;
   typedef enum logic [3:0] {
      SRC_LOW     = 4'h0,
      SRC_HIGH    = 4'h1,
      SRC_STEADY  = 4'h2,
      SRC_INSTANT = 4'h3,
      SRC_CARRIER = 4'h4,
      SRC_CAL     = 4'h5,
      SRC_FAULT   = 4'h6
   } agclk_src_e;
endpackage

//--- hdl/agclk_lockdet.sv
// Lock detector counter with restart and up/down styles
`timescale 1ns/100ps
module agclk_lockdet #(
   parameter int CNT_W = 10
) (
   input  wire logic             sys_clk,
   input  wire logic             srst,
   input  wire logic             cmp_valid,
   input  wire logic [3:0]       phase_err_cycles,
   input  wire logic             span_wide,
   input  wire logic             count_updown,
   input  wire logic [1:0]       thr_sel,
   output logic                  steady_lock_flag,
   output logic                  instant_lock_flag
);
   import agclk_pkg::*;

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             lock_r;
   logic             inst_r;

   // Window and thresholds are pure selects
   wire logic [3:0]       window     = span_wide ? WINDOW_WIDE : WINDOW_NARROW; // R10
   wire logic             in_window  = phase_err_cycles < window; // R10
   wire logic [CNT_W-1:0] lock_thr   = (thr_sel == 2'h0) ? LOCK_THR_0 :
                                       (thr_sel == 2'h1) ? LOCK_THR_1 :
                                       (thr_sel == 2'h2) ? LOCK_THR_2 : LOCK_THR_3; // R12
   wire logic [CNT_W-1:0] loss_thr   = (thr_sel == 2'h0) ? LOSS_THR_0 :
                                       (thr_sel == 2'h1) ? LOSS_THR_1 :
                                       (thr_sel == 2'h2) ? LOSS_THR_2 : LOSS_THR_3; // R12
   wire logic             cnt_full   = &cnt_r;
   wire logic             cnt_empty  = ~|cnt_r;

   // Counter saturates at both ends so a long run cannot wrap into a false lock
   always_comb begin
      cnt_nxt = cnt_r;
      if (cmp_valid) begin
         if (in_window) begin
            cnt_nxt = cnt_full ? cnt_r : cnt_r + 1'b1; // R16
         end else if (!count_updown) begin
            cnt_nxt = '0; // R11
         end else begin
            cnt_nxt = cnt_empty ? cnt_r : cnt_r - 1'b1; // R16
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_r  <= '0;
         lock_r <= 1'b0;
         inst_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         if (cmp_valid) begin
            inst_r <= in_window;
         end
         // Hysteresis: loss threshold sits below lock threshold
         if (cnt_nxt >= lock_thr) begin
            lock_r <= 1'b1; // R12
         end else if (cnt_nxt <= loss_thr) begin
            lock_r <= 1'b0; // R12
         end
      end
   end

   assign steady_lock_flag  = lock_r;
   assign instant_lock_flag = inst_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   restart_clear_a: assert property ( // R11
      cmp_valid && !in_window && !count_updown |=> cnt_r == 0)
      else $error("counter not cleared on miss in restart style");
   updown_step_a: assert property ( // R16
      cmp_valid && !in_window && count_updown && !cnt_empty |=> cnt_r == $past(cnt_r) - 1)
      else $error("counter not decremented on miss");
   window_hit_a: assert property ( // R10
      cmp_valid && phase_err_cycles == 4'h3 |=> inst_r == $past(span_wide))
      else $error("window width not honoured");
   lock_declare_a: assert property (cnt_r >= lock_thr && $stable(thr_sel) |-> lock_r) // R12
      else $error("lock not declared at threshold");
   lock_loss_a: assert property (cnt_r <= loss_thr && $stable(thr_sel) |-> !lock_r) // R12
      else $error("lock not dropped at loss threshold");
   lock_seen_c: cover property (!lock_r ##1 lock_r);
   lock_lost_c: cover property (lock_r ##1 !lock_r);
endmodule

//--- hdl/agclk_top.sv
// Gain-control thresholds, carrier sense, lock detection and status pin select
`timescale 1ns/100ps
module agclk_top #(
   parameter int MAG_W  = 8,
   parameter int TAPS_N = 9
) (
   input  wire logic              sys_clk,
   input  wire logic              srst,
   input  wire logic              cfg_wr_en,
   input  wire logic [6:0]        cfg_addr,
   input  wire logic [7:0]        cfg_wdata,
   output logic      [7:0]        cfg_rdata,
   input  wire logic              auto_gain_off,
   input  wire logic [1:0]        magnitude_avg_len,
   input  wire logic              rx_on,
   input  wire logic              mag_valid,
   input  wire logic [MAG_W-1:0]  mag_half_db,
   input  wire logic              phase_cmp_valid,
   input  wire logic [3:0]        phase_err_cycles,
   input  wire logic              cal_complete,
   input  wire logic              sequencing_fault_flag,
   input  wire logic [TAPS_N-1:0] clock_taps,
   output logic      [4:0]        gain_setting,
   output logic      [7:0]        strength_level,
   output logic                   carrier_sense,
   output logic                   steady_lock_flag,
   output logic                   instant_lock_flag,
   output logic                   status_pin
);
   import agclk_pkg::*;

   localparam int ACC_W = MAG_W + 4;

   logic [7:0]       start_cfg_r;
   logic [7:0]       raise_cfg_r;
   logic [7:0]       lock_cfg_r;
   logic [7:0]       rdata_r;
   logic [ACC_W-1:0] acc_r;
   logic [3:0]       samp_cnt_r;
   logic [MAG_W-1:0] avg_r;
   logic             avg_valid_r;
   logic [7:0]       level_r;
   logic             level_valid_r;
   logic             rx_on_r;
   logic [4:0]       gain_r;
   logic [4:0]       gain_nxt;
   logic             cs_r;
   logic             pin_r;
   logic             pin_nxt;

   // Field decode from the three configuration bytes
   wire logic [2:0] drop_margin  = start_cfg_r[7:F_MARGIN_LSB];
   wire logic [4:0] start_gain   = start_cfg_r[F_LEVEL_MSB:0];
   wire logic [2:0] raise_margin = raise_cfg_r[7:F_MARGIN_LSB];
   wire logic [4:0] sense_level  = raise_cfg_r[F_LEVEL_MSB:0];
   wire logic [3:0] pin_source   = lock_cfg_r[7:F_SRC_LSB];
   wire logic       span_wide    = lock_cfg_r[F_SPAN_BIT];
   wire logic       count_updown = lock_cfg_r[F_STYLE_BIT];
   wire logic [1:0] thr_sel      = lock_cfg_r[1:0];

   // Register port decode; unmapped addresses read zero and ignore writes
   wire logic wr_start = cfg_wr_en && (cfg_addr == ADDR_GAIN_START);
   wire logic wr_raise = cfg_wr_en && (cfg_addr == ADDR_GAIN_RAISE);
   wire logic wr_lock  = cfg_wr_en && (cfg_addr == ADDR_LOCK_CFG);
   wire logic [7:0] rd_mux = (cfg_addr == ADDR_GAIN_START) ? start_cfg_r :
                             (cfg_addr == ADDR_GAIN_RAISE) ? raise_cfg_r :
                             (cfg_addr == ADDR_LOCK_CFG)   ? lock_cfg_r  : 8'h00;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         start_cfg_r <= RST_GAIN_START; // R04
         raise_cfg_r <= RST_GAIN_RAISE; // R06
         lock_cfg_r  <= RST_LOCK_CFG;
         rdata_r     <= 8'h00;
      end else begin
         if (wr_start) start_cfg_r <= cfg_wdata;
         if (wr_raise) raise_cfg_r <= cfg_wdata;
         if (wr_lock) lock_cfg_r <= cfg_wdata;
         rdata_r <= rd_mux;
      end
   end
   assign cfg_rdata = rdata_r;

   // Averaging window: 2, 4, 8 or 16 samples, a power of two so the mean is a shift
   // Count and shift are worked out one bit wider, or length code 3 would wrap to zero
   wire logic [3:0]       last_samp = 4'((5'h02 << magnitude_avg_len) - 5'h01); // R15
   wire logic [ACC_W-1:0] acc_sum   = acc_r + ACC_W'(mag_half_db);
   wire logic [ACC_W-1:0] acc_mean  = acc_sum >> (3'(magnitude_avg_len) + 3'h1); // R15
   wire logic             acc_done  = mag_valid && (samp_cnt_r >= last_samp);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         acc_r       <= '0;
         samp_cnt_r  <= 4'h0;
         avg_r       <= '0;
         avg_valid_r <= 1'b0;
      end else begin
         avg_valid_r <= acc_done;
         if (acc_done) begin
            acc_r      <= '0;
            samp_cnt_r <= 4'h0;
            avg_r      <= acc_mean[MAG_W-1:0]; // R15
         end else if (mag_valid) begin
            acc_r      <= acc_sum;
            samp_cnt_r <= samp_cnt_r + 4'h1;
         end
      end
   end

   // Input is in 0.5 dB units, so a divide by three gives 1.5 dB steps
   wire logic [7:0] level_q = 8'(avg_r / LEVEL_DIVISOR); // R01

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         level_r       <= 8'h00;
         level_valid_r <= 1'b0;
      end else begin
         level_valid_r <= avg_valid_r;
         if (avg_valid_r) level_r <= level_q; // R01
      end
   end

   // Thresholds share the sense reference; sums stay within eight bits
   wire logic [7:0] raise_thr = 8'(sense_level) + SENSE_OFFSET + 8'(raise_margin); // R03 R06
   wire logic [7:0] drop_thr  = raise_thr + DROP_BASE + 8'(drop_margin); // R02
   wire logic       want_drop = level_r > drop_thr; // R02
   wire logic       want_rise = level_r < raise_thr; // R03
   wire logic       cs_now    = level_r > 8'(sense_level); // R06
   wire logic       rx_rise   = rx_on && !rx_on_r;

   // Gain loop steps one code per new level; a lowered ceiling pulls gain down at once
   always_comb begin
      gain_nxt = gain_r;
      if (rx_rise || auto_gain_off) begin
         gain_nxt = start_gain; // R04 R14
      end else if (gain_r > start_gain) begin
         gain_nxt = start_gain; // R05
      end else if (level_valid_r && want_drop && gain_r != 5'h00) begin
         gain_nxt = gain_r - 5'h01; // R02
      end else if (level_valid_r && want_rise && gain_r < start_gain) begin
         gain_nxt = gain_r + 5'h01; // R03 R05
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rx_on_r <= 1'b0;
         gain_r  <= RST_GAIN_START[4:0];
         cs_r    <= 1'b0;
      end else begin
         rx_on_r <= rx_on;
         gain_r  <= gain_nxt;
         cs_r    <= cs_now; // R07
      end
   end

   assign gain_setting   = gain_r;
   assign strength_level = level_r;
   assign carrier_sense  = cs_r;

   agclk_lockdet #(
      .CNT_W (10)
   ) u_lockdet (
      .sys_clk           (sys_clk),
      .srst              (srst),
      .cmp_valid         (phase_cmp_valid),
      .phase_err_cycles  (phase_err_cycles),
      .span_wide         (span_wide),
      .count_updown      (count_updown),
      .thr_sel           (thr_sel),
      .steady_lock_flag  (steady_lock_flag),
      .instant_lock_flag (instant_lock_flag)
   );

   // Status pin source select; flags are shown active low
   wire logic [3:0] tap_idx = pin_source - 4'h7;
   always_comb begin
      unique case (pin_source)
         SRC_LOW:     pin_nxt = 1'b0; // R08
         SRC_HIGH:    pin_nxt = 1'b1; // R08
         SRC_STEADY:  pin_nxt = !steady_lock_flag; // R09 R13
         SRC_INSTANT: pin_nxt = !instant_lock_flag; // R09
         SRC_CARRIER: pin_nxt = !cs_r; // R07
         SRC_CAL:     pin_nxt = !cal_complete; // R09
         SRC_FAULT:   pin_nxt = !sequencing_fault_flag; // R09
         default:     pin_nxt = (32'(tap_idx) < TAPS_N) ? clock_taps[tap_idx] : 1'b0; // R08
      endcase
   end

   // Registered pin avoids glitches while the source is changed
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pin_r <= 1'b0;
      end else begin
         pin_r <= pin_nxt;
      end
   end
   assign status_pin = pin_r;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   level_quant_a: assert property (avg_valid_r |=> level_r == 8'($past(avg_r) / 3)) // R01
      else $error("strength level not in 1.5 dB steps");
   gain_drop_a: assert property ( // R02
      level_valid_r && want_drop && gain_r != 0 && gain_r <= start_gain && !rx_rise
      && !auto_gain_off |=> gain_r == $past(gain_r) - 1)
      else $error("gain not lowered above drop threshold");
   gain_raise_a: assert property ( // R03
      level_valid_r && !want_drop && want_rise && gain_r < start_gain && !rx_rise
      && !auto_gain_off |=> gain_r == $past(gain_r) + 1)
      else $error("gain not raised below raise threshold");
   start_load_a: assert property (rx_on && !rx_on_r |=> gain_r == $past(start_gain)) // R04
      else $error("start gain not loaded on receive start");
   gain_ceiling_a: assert property ($stable(start_cfg_r) [*2] |-> gain_r <= start_gain) // R05
      else $error("gain above ceiling");
   auto_off_hold_a: assert property (auto_gain_off |=> gain_r == $past(start_gain)) // R14
      else $error("gain moved while auto gain off");
   carrier_pin_a: assert property (pin_source == 4'h4 |=> status_pin == !$past(cs_r)) // R07
      else $error("carrier sense not shown active low");
   force_pin_a: assert property (pin_source == 4'h1 |=> status_pin) // R08
      else $error("forced high source not driven");
   lock_pin_a: assert property ( // R09
      pin_source == 4'h2 |=> status_pin == !$past(steady_lock_flag))
      else $error("steady lock not shown active low");
   avg_span_a: assert property ( // R15
      magnitude_avg_len == 2'h3 && avg_valid_r |=> !avg_valid_r [*2])
      else $error("average finished too early");
   gain_drop_c: cover property (level_valid_r && want_drop ##1 gain_r != $past(gain_r));
   gain_rise_c: cover property (level_valid_r && want_rise ##1 gain_r != $past(gain_r));
   carrier_c:   cover property (pin_source == 4'h4 && cs_r ##1 !status_pin);
endmodule

//--- testbench/agclk_host_model.sv
// Host-side model that programs and reads back the configuration registers
`timescale 1ns/100ps
module agclk_host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] cfg_rdata,
   output logic            cfg_wr_en,
   output logic      [6:0] cfg_addr,
   output logic      [7:0] cfg_wdata
);
   import agclk_pkg::*;

   // Quiet bus at time zero
   initial begin
      cfg_wr_en = 1'b0;
      cfg_addr = 7'h00;
      cfg_wdata = 8'h00;
   end

   // One-cycle write strobe; data is scrambled afterwards so a stale byte cannot pass
   task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      cfg_addr <= addr;
      cfg_wdata <= data;
      cfg_wr_en <= 1'b1;
      @(posedge sys_clk);
      cfg_wr_en <= 1'b0;
      cfg_wdata <= ~data;
   endtask

   // Read data is registered, so it is taken one edge after the address
   task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
      @(posedge sys_clk);
      cfg_addr <= addr;
      @(posedge sys_clk);
      #1;
      data = cfg_rdata;
   endtask

   // Status pin as continuous lock indicator, with the given detector settings
   task automatic use_lock_indicator(input logic [3:0] detector_bits);
      write_reg(ADDR_LOCK_CFG, {4'h2, detector_bits});
   endtask
endmodule

//--- testbench/agc_threshold_and_lock_detect_bench.sv
// Self-checking bench for the gain thresholds, status pin and lock detector block
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module agc_threshold_and_lock_detect_bench;
   import agclk_pkg::*;
   logic       sys_clk, srst, cfg_wr_en, auto_gain_off, rx_on, mag_valid, phase_cmp_valid;
   logic       cal_complete, sequencing_fault_flag, carrier_sense, status_pin;
   logic       steady_lock_flag, instant_lock_flag;
   logic [1:0] magnitude_avg_len;
   logic [3:0] phase_err_cycles;
   logic [4:0] gain_setting;
   logic [6:0] cfg_addr;
   logic [7:0] cfg_wdata, cfg_rdata, mag_half_db, strength_level, rd;
   logic [8:0] clock_taps;
   int         miscompares, n_tests;

   agclk_top DUT (.sys_clk, .srst, .cfg_wr_en, .cfg_addr, .cfg_wdata, .cfg_rdata,
      .auto_gain_off, .magnitude_avg_len, .rx_on, .mag_valid, .mag_half_db,
      .phase_cmp_valid, .phase_err_cycles, .cal_complete, .sequencing_fault_flag,
      .clock_taps, .gain_setting, .strength_level, .carrier_sense, .steady_lock_flag,
      .instant_lock_flag, .status_pin);
   agclk_host_model host (.sys_clk, .cfg_rdata, .cfg_wr_en, .cfg_addr, .cfg_wdata);

   // 250 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Cuts a hung run short; counts as a mismatch
   initial begin
      repeat (50000) @(posedge sys_clk);
      miscompares++;
      $display("CHECK FAILED run length expected 0 seen 1");
      give_verdict();
   end

   // Wait n edges, then step past the edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
   endtask

   // Back-to-back phase comparisons, all with the same offset
   task automatic phase(input int n, input logic [3:0] err);
      repeat (n) begin
         @(posedge sys_clk);
         phase_cmp_valid <= 1'b1;
         phase_err_cycles <= err;
      end
      @(posedge sys_clk);
      phase_cmp_valid <= 1'b0;
      tick(2);
   endtask

   // Back-to-back magnitude samples; the pin answers four edges after the last one
   task automatic mags(input int n, input logic [7:0] v);
      repeat (n) begin
         @(posedge sys_clk);
         mag_valid <= 1'b1;
         mag_half_db <= v;
      end
      @(posedge sys_clk);
      mag_valid <= 1'b0;
      tick(3);
   endtask

   // Reset values, read/write access and an unmapped address
   task automatic t_registers();
      logic [7:0] exp [4] = '{8'h38, 8'h38, 8'h00, 8'h00};
      for (int i = 0; i < 4; i++) begin
         host.read_reg(7'(8'h13 + i), rd);
         `CHK("register reset", exp[i], rd);
      end
      `CHK("gain after reset", 5'h18, gain_setting);
      host.write_reg(ADDR_GAIN_RAISE, 8'h55);
      host.read_reg(ADDR_GAIN_RAISE, rd);
      `CHK("register readback", 8'h55, rd);
      host.write_reg(ADDR_GAIN_RAISE, 8'h38);
   endtask

   // Every status pin source, with all level inputs in both polarities
   task automatic t_pin_select();
      logic e;
      for (int p = 0; p < 2; p++) begin
         @(posedge sys_clk) cal_complete <= ~p[0];
         sequencing_fault_flag <= p[0];
         clock_taps <= p[0] ? 9'h0AA : 9'h155;
         for (int c = 0; c < 16; c++) begin
            host.write_reg(ADDR_LOCK_CFG, {4'(c), 4'h0});
            tick(1);
            e = (c == 0) ? 1'b0 : (c <= 4) ? 1'b1 : (c == 5) ? ~cal_complete :
                (c == 6) ? ~sequencing_fault_flag : clock_taps[c-7];
            `CHK("status pin source", e, status_pin);
         end
      end
   endtask

   // Up/down style: lock and loss points for every threshold choice
   task automatic t_lock_levels();
      int lk;
      for (int s = 0; s < 4; s++) begin
         do_reset();
         lk = (128 << s) - 1;
         host.use_lock_indicator({2'b01, 2'(s)});
         phase(lk - 1, 4'h1);
         `CHK("lock below threshold", 1'b0, steady_lock_flag);
         phase(1, 4'h1);
         `CHK("lock at threshold", 1'b1, steady_lock_flag);
         `CHK("pin shows lock low", 1'b0, status_pin);
         phase(15, 4'h2);
         `CHK("lock above loss point", 1'b1, steady_lock_flag);
         `CHK("edge offset out of window", 1'b0, instant_lock_flag);
         phase(1, 4'h2);
         `CHK("lock lost at loss point", 1'b0, steady_lock_flag);
      end
   endtask

   // Restart style with the wide window, instant flag on the pin
   task automatic t_lock_restart();
      do_reset();
      host.write_reg(ADDR_LOCK_CFG, 8'h38);
      phase(127, 4'h3);
      `CHK("wide window lock", 1'b1, steady_lock_flag);
      `CHK("instant pin low", 1'b0, status_pin);
      phase(1, 4'h4);
      `CHK("restart drops lock", 1'b0, steady_lock_flag);
      `CHK("instant pin high", 1'b1, status_pin);
      phase(126, 4'h0);
      `CHK("count restarted", 1'b0, steady_lock_flag);
   endtask

   // Gain steps at the raise and drop boundaries, carrier sense on the pin
   task automatic t_gain_loop();
      logic [7:0] mg [6] = '{8'h78, 8'h6F, 8'h63, 8'h60, 8'h60, 8'h48};
      logic [4:0] gn [6] = '{5'h17, 5'h17, 5'h17, 5'h18, 5'h18, 5'h18};
      do_reset();
      magnitude_avg_len <= 2'h0;
      host.write_reg(ADDR_LOCK_CFG, 8'h40);
      for (int i = 0; i < 6; i++) begin
         mags(2, mg[i]);
         `CHK("strength level", mg[i] / 8'h03, strength_level);
         `CHK("gain step", gn[i], gain_setting);
         `CHK("carrier sense", mg[i] > 8'h4A, carrier_sense);
         `CHK("carrier pin", ~(mg[i] > 8'h4A), status_pin);
      end
      @(posedge sys_clk) magnitude_avg_len <= 2'h3;
      mags(15, 8'h78);
      `CHK("partial average", 8'h18, strength_level);
      mags(1, 8'h78);
      `CHK("sixteen sample average", 8'h28, strength_level);
      @(posedge sys_clk) auto_gain_off <= 1'b1;
      tick(2);
      `CHK("manual gain", 5'h18, gain_setting);
      mags(16, 8'h78);
      `CHK("manual gain held", 5'h18, gain_setting);
      @(posedge sys_clk) auto_gain_off <= 1'b0;
      mags(16, 8'h78);
      `CHK("gain dropped again", 5'h17, gain_setting);
      @(posedge sys_clk) rx_on <= 1'b0;
      tick(2);
      @(posedge sys_clk) rx_on <= 1'b1;
      tick(3);
      `CHK("gain loaded on receive", 5'h18, gain_setting);
      host.write_reg(ADDR_GAIN_START, 8'h2A);
      mags(16, 8'h3C);
      `CHK("gain ceiling", 5'h0A, gain_setting);
      // The two middle lengths, so every averaging code is exercised
      @(posedge sys_clk) magnitude_avg_len <= 2'h1;
      mags(4, 8'h5A);
      `CHK("four sample average", 8'h1E, strength_level);
      @(posedge sys_clk) magnitude_avg_len <= 2'h2;
      mags(8, 8'h2D);
      `CHK("eight sample average", 8'h0F, strength_level);
      `CHK("carrier clear", 1'b0, carrier_sense);
   endtask

   initial begin
      srst = 1'b1;
      auto_gain_off = 1'b0;
      magnitude_avg_len = 2'h0;
      rx_on = 1'b1;
      mag_valid = 1'b0;
      mag_half_db = 8'h00;
      phase_cmp_valid = 1'b0;
      phase_err_cycles = 4'h0;
      cal_complete = 1'b0;
      sequencing_fault_flag = 1'b0;
      clock_taps = 9'h000;
      miscompares = 0;
      n_tests = 0;
      do_reset();
      t_registers();
      t_pin_select();
      t_lock_levels();
      t_lock_restart();
      t_gain_loop();
      give_verdict();
   end
endmodule
